/* design/cpu_ops_pkg.sv */
// ************************************
// opcodes, flags, map and carriers
// ************************************
package cpu_ops_pkg;
   localparam logic [7:0] OP_PRE = 8'h9e;
   localparam logic [7:0] OP_TRAP = 8'h83;
   localparam logic [7:0] OP_TAP = 8'h84;
   localparam logic [7:0] OP_F2A = 8'h85;
   localparam logic [7:0] OP_A2XL = 8'h97;
   localparam logic [7:0] OP_XL2A = 8'h9f;
   localparam logic [7:0] OP_S2X = 8'h95;
   localparam logic [7:0] OP_X2S = 8'h94;
   localparam logic [7:0] OP_WAIT = 8'h8f;
   localparam logic [7:0] OP_TEST_DIR = 8'h3d;
   localparam logic [7:0] OP_TEST_A = 8'h4d;
   localparam logic [7:0] OP_TEST_XL = 8'h5d;
   localparam logic [7:0] OP_TEST_XB = 8'h6d;
   localparam logic [7:0] OP_TEST_XP = 8'h7d;
   localparam logic [7:0] OP_TEST_XW = 8'h32;
   localparam logic [7:0] OP_TEST_XBI = 8'h41;
   localparam logic [7:0] OP_TEST_SB = 8'h6d;
   localparam logic [7:0] OP_TEST_SW = 8'hdd;
   localparam logic [7:0] OP_MOV_D2D = 8'h4e;
   localparam logic [7:0] OP_MOV_DIXP = 8'h5e;
   localparam logic [7:0] OP_MOV_IMM2D = 8'h6e;
   localparam logic [7:0] OP_MOV_IXPD = 8'h7e;
   localparam logic [3:0] CYC_1 = 4'h1;
   localparam logic [3:0] CYC_2 = 4'h2;
   localparam logic [3:0] CYC_3 = 4'h3;
   localparam logic [3:0] CYC_4 = 4'h4;
   localparam logic [3:0] CYC_5 = 4'h5;
   localparam logic [3:0] CYC_SWI = 4'h9;
   localparam logic [3:0] TRAP_PCL = 4'h1;
   localparam logic [3:0] TRAP_PCH = 4'h2;
   localparam logic [3:0] TRAP_X = 4'h3;
   localparam logic [3:0] TRAP_A = 4'h4;
   localparam logic [3:0] TRAP_FLG = 4'h5;
   localparam logic [3:0] TRAP_VH = 4'h6;
   localparam logic [3:0] TRAP_VL = 4'h7;
   localparam int FLG_V = 7;
   localparam int FLG_I = 3;
   localparam int FLG_N = 2;
   localparam int FLG_Z = 1;
   localparam logic [7:0] FLAG_FIXED = 8'h60;
   localparam logic [7:0] FLAGS_RST = 8'h68;
   localparam logic [15:0] SP_RST = 16'h00ff;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [15:0] VEC_SWI = 16'hfffc;
   localparam logic [15:0] VEC_IRQ = 16'hfffa;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PC = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_IXSP = 8'h0c;
   localparam int CTRL_RUN = 0;
   localparam int STAT_WAIT = 24;
   typedef enum logic [3:0] {MD_NONE, MD_DIR, MD_XP, MD_XB, MD_XW, MD_SB, MD_SW, MD_XI, MD_XBI} mode_type;
   typedef enum logic [3:0] {K_NONE, K_TEST, K_TEST_A, K_TEST_XL, K_A2XL, K_XL2A, K_F2A, K_WAIT, K_TRAP, K_TAP,
      K_S2X, K_X2S, K_MOV_D2D, K_MOV_DIXP, K_MOV_IMM2D, K_MOV_IXPD} kind_type;
   typedef enum logic [1:0] {S_FETCH, S_PRE, S_EXEC, S_WAIT} state_type;
   typedef struct packed {kind_type kind; mode_type mode; logic [1:0] nbytes; logic [3:0] cycles;} dec_type;
   typedef struct packed {logic [15:0] addr; logic [7:0] wdata; logic we; logic re;} mem_req_type;
endpackage

/* design/cpu_transfer_trap_wait_ops.sv */
`timescale 1ns/10ps
`default_nettype none
module cpu_transfer_trap_wait_ops import cpu_ops_pkg::*; (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output mem_req_type mem_req,
   input wire logic [7:0] mem_rdata,
   input wire logic irq_req,
   output logic waiting
);
   // ************************************
   // decode
   // ************************************
   function automatic dec_type decode(input logic [7:0] op, input logic pre);
      dec_type d;
      d = '{K_NONE, MD_NONE, 2'd0, CYC_1};
      if (pre) begin
         d.cycles = CYC_2;
         if (op == OP_TEST_SB) d = '{K_TEST, MD_SB, 2'd1, CYC_4};
         else if (op == OP_TEST_SW) d = '{K_TEST, MD_SW, 2'd2, CYC_5};
      end else begin
         case (op)
            OP_TRAP: d = '{K_TRAP, MD_NONE, 2'd0, CYC_SWI};
            OP_TAP: d = '{K_TAP, MD_NONE, 2'd0, CYC_2};
            OP_A2XL: d = '{K_A2XL, MD_NONE, 2'd0, CYC_1};
            OP_F2A: d = '{K_F2A, MD_NONE, 2'd0, CYC_1};
            OP_XL2A: d = '{K_XL2A, MD_NONE, 2'd0, CYC_1};
            OP_S2X: d = '{K_S2X, MD_NONE, 2'd0, CYC_2};
            OP_X2S: d = '{K_X2S, MD_NONE, 2'd0, CYC_2};
            OP_WAIT: d = '{K_WAIT, MD_NONE, 2'd0, CYC_1};
            OP_TEST_DIR: d = '{K_TEST, MD_DIR, 2'd1, CYC_3};
            OP_TEST_A: d = '{K_TEST_A, MD_NONE, 2'd0, CYC_1};
            OP_TEST_XL: d = '{K_TEST_XL, MD_NONE, 2'd0, CYC_1};
            OP_TEST_XB: d = '{K_TEST, MD_XB, 2'd1, CYC_3};
            OP_TEST_XP: d = '{K_TEST, MD_XP, 2'd0, CYC_2};
            OP_TEST_XW: d = '{K_TEST, MD_XW, 2'd2, CYC_4};
            OP_TEST_XBI: d = '{K_TEST, MD_XBI, 2'd1, CYC_4};
            OP_MOV_D2D: d = '{K_MOV_D2D, MD_DIR, 2'd2, CYC_5};
            OP_MOV_DIXP: d = '{K_MOV_DIXP, MD_XI, 2'd1, CYC_4};
            OP_MOV_IMM2D: d = '{K_MOV_IMM2D, MD_DIR, 2'd2, CYC_4};
            OP_MOV_IXPD: d = '{K_MOV_IXPD, MD_XI, 2'd1, CYC_4};
            default: ;
         endcase
      end
      return d;
   endfunction

   state_type state, next_state;
   logic [3:0] step, next_step;
   logic [15:0] pc, next_pc, sp, next_sp, hx, next_hx, opnd, next_opnd, ea, vec;
   logic [7:0] acc, next_acc, flags, next_flags, op, next_op, tmp, next_tmp;
   logic pre, next_pre, vec_irq, next_vec_irq, run, next_run;
   logic [31:0] next_prdata;
   logic next_pslverr, irq_take, fetch_go, apb_pc_wr, ph1;
   logic [3:0] p_base, p1, p2;
   mem_req_type req;
   dec_type d, df, dp;

   assign d = decode(op, pre);
   assign irq_take = irq_req && !flags[FLG_I];
   assign fetch_go = state == S_FETCH && run && !irq_take;
   assign p_base = pre ? CYC_2 : CYC_1;
   assign p1 = p_base + {2'b00, d.nbytes};
   assign p2 = p1 + CYC_1;
   assign ph1 = state == S_EXEC && d.kind != K_TRAP && step == p1;
   assign vec = vec_irq ? VEC_IRQ : VEC_SWI;
   assign mem_req = req;
   assign waiting = state == S_WAIT;

   // ************************************
   // operand address
   // ************************************
   always_comb begin
      case (d.mode)
         MD_DIR: ea = {8'h00, opnd[7:0]};
         MD_XP, MD_XI: ea = hx;
         MD_XB, MD_XBI: ea = hx + {8'h00, opnd[7:0]};
         MD_XW: ea = hx + opnd;
         MD_SB: ea = sp + {8'h00, opnd[7:0]};
         MD_SW: ea = sp + opnd;
         default: ea = hx;
      endcase
   end

   // ************************************
   // execution sequencer
   // ************************************
   always_comb begin
      next_state = state;
      next_step = step;
      next_pc = pc;
      next_sp = sp;
      next_hx = hx;
      next_acc = acc;
      next_flags = flags;
      next_op = op;
      next_opnd = opnd;
      next_tmp = tmp;
      next_pre = pre;
      next_vec_irq = vec_irq;
      req = '0;
      df = decode(mem_rdata, 1'b0);
      dp = decode(mem_rdata, 1'b1);
      case (state)
         S_FETCH: begin
            // run is only looked at here, so a stop lets the current instruction finish
            if (run && irq_take) begin
               next_state = S_EXEC;
               next_op = OP_TRAP;
               next_pre = 1'b0;
               next_vec_irq = 1'b1;
               next_step = TRAP_PCL;
            end else if (run) begin
               req.re = 1'b1;
               req.addr = pc;
               next_pc = pc + 16'h0001;
               next_op = mem_rdata;
               next_pre = 1'b0;
               next_vec_irq = 1'b0;
               next_step = CYC_1;
               if (mem_rdata == OP_PRE) begin
                  next_pre = 1'b1;
                  next_state = S_PRE;
               end else if (df.cycles > CYC_1) begin
                  next_state = S_EXEC;
               end else begin
                  case (df.kind)
                     K_A2XL: next_hx[7:0] = acc;
                     K_XL2A: next_acc = hx[7:0];
                     K_F2A: next_acc = flags;
                     K_TEST_A, K_TEST_XL: begin
                        next_tmp = df.kind == K_TEST_A ? acc : hx[7:0];
                        next_flags[FLG_V] = 1'b0;
                        next_flags[FLG_N] = next_tmp[7];
                        next_flags[FLG_Z] = next_tmp == 8'h00;
                     end
                     K_WAIT: begin
                        next_flags[FLG_I] = 1'b0;
                        next_state = S_WAIT;
                     end
                     default: ;
                  endcase
               end
            end
         end
         S_PRE: begin
            req.re = 1'b1;
            req.addr = pc;
            next_pc = pc + 16'h0001;
            next_op = mem_rdata;
            next_step = CYC_2;
            next_state = dp.cycles > CYC_2 ? S_EXEC : S_FETCH;
         end
         S_EXEC: begin
            next_step = step + CYC_1;
            if (step == d.cycles - CYC_1) next_state = S_FETCH;
            if (d.kind == K_TRAP) begin
               req.we = step >= TRAP_PCL && step <= TRAP_FLG;
               req.addr = sp;
               if (req.we) next_sp = sp - 16'h0001;
               case (step)
                  TRAP_PCL: req.wdata = pc[7:0];
                  TRAP_PCH: req.wdata = pc[15:8];
                  TRAP_X: req.wdata = hx[7:0];
                  TRAP_A: req.wdata = acc;
                  TRAP_FLG: begin
                     req.wdata = flags;
                     next_flags[FLG_I] = 1'b1;
                  end
                  TRAP_VH: begin
                     req.re = 1'b1;
                     req.addr = vec;
                     next_pc[15:8] = mem_rdata;
                  end
                  TRAP_VL: begin
                     req.re = 1'b1;
                     req.addr = vec + 16'h0001;
                     next_pc[7:0] = mem_rdata;
                  end
                  default: ;
               endcase
            end else if (step < p1) begin
               req.re = 1'b1;
               req.addr = pc;
               next_pc = pc + 16'h0001;
               next_opnd = {opnd[7:0], mem_rdata};
            end else if (step == p1) begin
               case (d.kind)
                  K_TAP: next_flags = acc | FLAG_FIXED;
                  K_S2X: next_hx = sp + 16'h0001;
                  K_X2S: next_sp = hx - 16'h0001;
                  K_MOV_IMM2D: begin
                     req.we = 1'b1;
                     req.addr = {8'h00, opnd[7:0]};
                     req.wdata = opnd[15:8];
                  end
                  K_TEST, K_MOV_IXPD, K_MOV_DIXP, K_MOV_D2D: begin
                     req.re = 1'b1;
                     // direct-source moves read the page, not the index pair
                     req.addr = d.kind == K_MOV_D2D ? {8'h00, opnd[15:8]} :
                        d.kind == K_MOV_DIXP ? {8'h00, opnd[7:0]} : ea;
                     if (d.mode == MD_XBI || d.kind == K_MOV_IXPD) next_hx = hx + 16'h0001;
                  end
                  default: ;
               endcase
               next_tmp = d.kind == K_MOV_IMM2D ? opnd[15:8] : mem_rdata;
               if (d.kind == K_TEST || d.kind >= K_MOV_D2D) begin
                  next_flags[FLG_V] = 1'b0;
                  next_flags[FLG_N] = next_tmp[7];
                  next_flags[FLG_Z] = next_tmp == 8'h00;
               end
            end else if (step == p2 && d.kind >= K_MOV_D2D && d.kind != K_MOV_IMM2D) begin
               req.we = 1'b1;
               req.wdata = tmp;
               req.addr = d.kind == K_MOV_DIXP ? hx : {8'h00, opnd[7:0]};
               if (d.kind == K_MOV_DIXP) next_hx = hx + 16'h0001;
            end
         end
         S_WAIT: begin
            // only an unmasked request wakes the core; reset also leaves here
            if (irq_take) begin
               next_state = S_EXEC;
               next_op = OP_TRAP;
               next_pre = 1'b0;
               next_vec_irq = 1'b1;
               next_step = TRAP_PCL;
            end
         end
         default: next_state = S_FETCH;
      endcase
      if (apb_pc_wr) next_pc = pwdata[15:0];
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= S_FETCH;
         step <= 4'h0;
         pc <= PC_RST;
         sp <= SP_RST;
         hx <= 16'h0000;
         acc <= 8'h00;
         flags <= FLAGS_RST;
         op <= 8'h00;
         opnd <= 16'h0000;
         tmp <= 8'h00;
         pre <= 1'b0;
         vec_irq <= 1'b0;
      end else begin
         state <= next_state;
         step <= next_step;
         pc <= next_pc;
         sp <= next_sp;
         hx <= next_hx;
         acc <= next_acc;
         flags <= next_flags;
         op <= next_op;
         opnd <= next_opnd;
         tmp <= next_tmp;
         pre <= next_pre;
         vec_irq <= next_vec_irq;
      end
   end

   // ************************************
   // apb slave
   // ************************************
   // answer is sampled in the setup phase so read data leaves a flop with no wait state
   assign pready = psel && penable;
   assign apb_pc_wr = pready && pwrite && paddr == A_PC && !pslverr;

   always_comb begin
      next_prdata = prdata;
      next_pslverr = pslverr;
      next_run = run;
      if (psel && !penable) begin
         next_prdata = 32'h0000_0000;
         next_pslverr = 1'b0;
         if (paddr == A_CTRL) next_prdata[CTRL_RUN] = run;
         else if (paddr == A_PC) begin
            next_prdata[15:0] = pc;
            next_pslverr = pwrite && run;
         end else if (paddr == A_STAT) begin
            next_prdata = {7'h00, waiting, flags, hx[7:0], acc};
            next_pslverr = pwrite;
         end else if (paddr == A_IXSP) begin
            next_prdata = {sp, hx};
            next_pslverr = pwrite;
         end else next_pslverr = 1'b1;
      end
      if (pready && pwrite && paddr == A_CTRL && !pslverr) next_run = pwdata[CTRL_RUN];
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         run <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         run <= next_run;
      end
   end

   // ************************************
   // assertions
   // ************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   trap_push_a: assert property (state == S_EXEC && d.kind == K_TRAP && step == TRAP_PCL
      |-> req.we && req.addr == sp && req.wdata == pc[7:0] ##4 req.wdata == $past(flags, 4) ##1 sp == $past(sp, 5) - 16'h0005)
      else $error("trap stacking order wrong");
   trap_len_a: assert property (fetch_go && mem_rdata == OP_TRAP |-> ##9 state == S_FETCH && flags[FLG_I])
      else $error("trap length or mask wrong");
   tap_copy_a: assert property (fetch_go && mem_rdata == OP_TAP |-> ##2 state == S_FETCH && flags == (acc | FLAG_FIXED))
      else $error("flags not loaded from acc");
   acc_index_a: assert property (fetch_go && mem_rdata == OP_A2XL |=> hx[7:0] == $past(acc) && $stable(flags))
      else $error("index low not loaded");
   flags_acc_a: assert property (fetch_go && mem_rdata == OP_F2A |=> acc == $past(flags) && $stable(flags))
      else $error("acc not loaded from flags");
   test_flags_a: assert property (fetch_go && mem_rdata == OP_TEST_A
      |=> !flags[FLG_V] && flags[FLG_Z] == ($past(acc) == 8'h00) && flags[FLG_N] == $past(acc[7]))
      else $error("test flags wrong");
   test_len_a: assert property (fetch_go && mem_rdata == OP_TEST_DIR
      |=> state == S_EXEC ##1 state == S_EXEC ##1 state == S_FETCH)
      else $error("direct test length wrong");
   sp_index_a: assert property (fetch_go && mem_rdata == OP_S2X |-> ##2 hx == $past(sp, 2) + 16'h0001)
      else $error("index pair not sp plus one");
   index_sp_a: assert property (fetch_go && mem_rdata == OP_X2S |-> ##2 sp == $past(hx, 2) - 16'h0001)
      else $error("sp not index pair minus one");
   wait_stop_a: assert property (fetch_go && mem_rdata == OP_WAIT |=> waiting && !flags[FLG_I] && !req.re)
      else $error("wait did not halt");
   post_inc_a: assert property (ph1 && d.kind == K_MOV_IXPD |-> req.addr == hx ##1 hx == $past(hx) + 16'h0001)
      else $error("post increment missing");
   wake_a: assert property (waiting && !irq_take |=> waiting && !req.re)
      else $error("fetch during wait");

   trap_seen_c: cover property (fetch_go && mem_rdata == OP_TRAP ##9 state == S_FETCH);
   wake_seen_c: cover property (waiting && irq_req ##1 state == S_EXEC);
   mov_direct_c: cover property (ph1 && d.kind == K_MOV_D2D);
   sp_test_c: cover property (ph1 && d.mode == MD_SB);
endmodule
`default_nettype wire

/* sim/cpu_transfer_trap_wait_ops_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module cpu_transfer_trap_wait_ops_tb_top import cpu_ops_pkg::*;;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq_req, waiting;
   logic [7:0] paddr, mem_rdata;
   logic [31:0] pwdata, prdata, rd;
   mem_req_type mem_req;
   int n_fail, checks, cyc, k;
   int fc[int];
   logic [15:0] ca [11] = '{16'h0, 16'h2, 16'h3, 16'h4, 16'h5, 16'h8, 16'h200, 16'h201, 16'h202, 16'h203, 16'h204};
   logic [15:0] cb [11] = '{16'h2, 16'h3, 16'h4, 16'h5, 16'h8, 16'h200, 16'h201, 16'h202, 16'h203, 16'h204, 16'h205};
   logic [31:0] cn [11] = '{3, 1, 1, 1, 4, 9, 2, 1, 1, 2, 2};
   logic [15:0] sa [10] = '{16'hff, 16'hfe, 16'hfd, 16'hfc, 16'hfb, 16'hfa, 16'hf9, 16'hf8, 16'hf7, 16'hf6};
   logic [7:0] sv [10] = '{8'h09, 8'h00, 8'h6c, 8'h6c, 8'h6a, 8'h06, 8'h02, 8'hfb, 8'hfb, 8'hf3};

   cpu_transfer_trap_wait_ops uut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_req(mem_req), .mem_rdata(mem_rdata), .irq_req(irq_req), .waiting(waiting));
   mem_partner mm (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // fetch times per address, sampled mid-cycle where mem_req is settled
   always @(negedge clk) begin
      cyc++;
      if (mem_req.re === 1'b1 && !fc.exists(int'(mem_req.addr))) fc[int'(mem_req.addr)] = cyc;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n == 20) n_fail++;
      rd = prdata;
      check({31'h0, pslverr}, {31'h0, err});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task ld(input logic [15:0] a, input logic [7:0] b[$]);
      foreach (b[i]) mm.mem[a + 16'(i)] = b[i];
   endtask

   task wait_for(input logic lvl);
      int n;
      n = 0;
      while (waiting !== lvl && n < 200) begin
         n++;
         @(posedge clk);
      end
      check({31'h0, waiting}, {31'h0, lvl});
   endtask

   task conclude;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      conclude;
   end

   initial begin
      resetn = 1'b0;
      {psel, penable, pwrite, irq_req} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      xfer(A_STAT, 1'b0, 32'h0, 1'b0);
      check(rd, 32'h00680000);
      xfer(A_IXSP, 1'b0, 32'h0, 1'b0);
      check(rd, 32'h00ff0000);
      xfer(8'h10, 1'b0, 32'h0, 1'b1);
      xfer(A_STAT, 1'b1, 32'h0, 1'b1);
      ld(16'h0000, '{8'h3d, 8'h40, 8'h85, 8'h97, 8'h5d, 8'h9e, 8'h6d, 8'h02, 8'h83});
      ld(16'h0200, '{8'h95, 8'h9f, 8'h4d, 8'h94, 8'h84, 8'h8f});
      ld(16'hfffa, '{8'h03, 8'h00, 8'h02, 8'h00});
      mm.mem[16'h0040] = 8'h80;
      mm.mem[16'h0300] = 8'h8f;
      xfer(A_CTRL, 1'b1, 32'h1, 1'b0);
      wait_for(1'b1);
      irq_req <= 1'b1;
      wait_for(1'b0);
      irq_req <= 1'b0;
      wait_for(1'b1);
      // waiting, flags f3, index low fb, acc fb
      xfer(A_STAT, 1'b0, 32'h0, 1'b0);
      check(rd, 32'h01f3fbfb);
      xfer(A_IXSP, 1'b0, 32'h0, 1'b0);
      check(rd, 32'h00f500fb);
      xfer(A_PC, 1'b1, 32'h0, 1'b1);
      xfer(A_PC, 1'b0, 32'h0, 1'b0);
      check(rd, 32'h00000301);
      for (k = 0; k < 10; k++) check({24'h0, mm.mem[sa[k]]}, {24'h0, sv[k]});
      for (k = 0; k < 11; k++) check(32'(fc[int'(cb[k])] - fc[int'(ca[k])]), cn[k]);
      // second pass: wake through a new request vector into the move program
      ld(16'h0400, '{8'h6e, 8'h55, 8'h30, 8'h7e, 8'h31, 8'h5e, 8'h30, 8'h4e, 8'h30, 8'h32, 8'h8f});
      ld(16'hfffa, '{8'h04, 8'h00});
      irq_req <= 1'b1;
      wait_for(1'b0);
      irq_req <= 1'b0;
      wait_for(1'b1);
      check({24'h0, mm.mem[16'h0030]}, 32'h55);
      check({24'h0, mm.mem[16'h0031]}, 32'h6a);
      check({24'h0, mm.mem[16'h00fc]}, 32'h55);
      check({24'h0, mm.mem[16'h0032]}, 32'h55);
      xfer(A_IXSP, 1'b0, 32'h0, 1'b0);
      check(rd, 32'h00f000fd);
      xfer(A_STAT, 1'b0, 32'h0, 1'b0);
      check(rd, 32'h0171fdfb);
      xfer(A_CTRL, 1'b1, 32'h0, 1'b0);
      xfer(A_PC, 1'b1, 32'h0, 1'b0);
      conclude;
   end
endmodule
`default_nettype wire

/* sim/mem_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module mem_partner import cpu_ops_pkg::*; (
   input wire logic clk,
   input wire mem_req_type mem_req,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] last;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      last = 8'h00;
   end
   // idle bus shows the inverse of the last byte, so stale data cannot pass
   assign mem_rdata = mem_req.re ? mem[mem_req.addr] : ~last;
   always @(posedge clk) begin
      if (mem_req.re) last <= mem[mem_req.addr];
      if (mem_req.we) mem[mem_req.addr] <= mem_req.wdata;
   end
endmodule
`default_nettype wire
